// [rtl/tws_pkg.sv]
/*
  Constants, widths, register map and phase encoding of the tape write
  sequencer. Assumes a 200 MHz system clock and APB register access.
*/
// Contract
// - Write call sets the write trigger; busy is shown while it is set.
// - While the write trigger is set, request write status from the tape unit.
// - The write delay trigger is set together with the write trigger.
// - Go is set when write delay is set and selected-in-write is active.
// - In write status, write delay steps the delay counter in millisecond mode.
// - Load point trigger, caught at the write call, picks the ending delay count.
// - Without load point, delay count 32 sets write condition.
// - At load point, write condition waits for delay count 320.
// - The ending delay pulse clears write delay and resets the counter.
// - Write condition gates drive pulses to the write clock, cycling repeatedly.
// - Write condition coming on also sets the write release trigger.
// - Read condition sets at load point delay end, else at count 32.
// - Write step one clears the character register.
// - Write step three loads active input data lines into the character register.
// - Write step five always sets the no-echo trigger.
// - Write step nine sends a write pulse to the tape unit.
// - Write step nine samples the parity error of the character register.
// - Sampled parity error sets parity indicator and adapter error.
// - Echo clears no-echo; still set at step fourteen flags echo error.
package tws_pkg;
  localparam int CLK_MHZ        = 200;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int DELAY_STEP_US  = 1000;
  localparam int DELAY_STEP_CYC = DELAY_STEP_US * CLK_MHZ;
  localparam int DRIVE_NS_A     = 100;
  localparam int DRIVE_NS_B     = 60;
  localparam int DRIVE_CYC_A    = DRIVE_NS_A / CLK_PERIOD_NS;
  localparam int DRIVE_CYC_B    = DRIVE_NS_B / CLK_PERIOD_NS;

  localparam int            DCNT_W                       = 9;
  localparam logic [8:0]    START_DELAY_COUNT_SHORT      = 9'h020;
  localparam logic [8:0]    START_DELAY_COUNT_LOAD_POINT = 9'h140;
  localparam logic [8:0]    DELAY_COUNT_READ_ENABLE      = 9'h020;

  localparam logic [3:0] WRITE_STEP_IDLE     = 4'h0;
  localparam logic [3:0] WRITE_STEP_ONE      = 4'h1;
  localparam logic [3:0] WRITE_STEP_THREE    = 4'h3;
  localparam logic [3:0] WRITE_STEP_FIVE     = 4'h5;
  localparam logic [3:0] WRITE_STEP_NINE     = 4'h9;
  localparam logic [3:0] WRITE_STEP_FOURTEEN = 4'he;
  localparam logic [3:0] WRITE_STEP_LAST     = 4'he;

  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] ERROR_OFS  = 12'h008;

  localparam int CTRL_ODD_BIT   = 0;
  localparam int CTRL_MODEL_BIT = 1;
  localparam int CTRL_STOP_BIT  = 2;
  localparam logic CTRL_ODD_RESET   = 1'h1;
  localparam logic CTRL_MODEL_RESET = 1'h0;

  localparam int ERR_PARITY_BIT  = 0;
  localparam int ERR_ECHO_BIT    = 1;
  localparam int ERR_ADAPTER_BIT = 2;

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_START = 2'b01,
    PH_WRITE = 2'b10
  } tws_phase_t;
endpackage

// [rtl/tws_sequencer.sv]
/*
  Write start-up and per-character sequencer of a magnetic tape adapter,
  with an APB register slave. Assumes tape and system pins are asynchronous
  to sys_clk; the tape unit answers write status and echoes on its own.
*/
`timescale 1ns/1ps
`default_nettype none
module tws_sequencer #(
  parameter int DATA_W         = 7,
  parameter int DELAY_STEP_CYC = tws_pkg::DELAY_STEP_CYC,
  parameter int DRIVE_CYC_A    = tws_pkg::DRIVE_CYC_A,
  parameter int DRIVE_CYC_B    = tws_pkg::DRIVE_CYC_B
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              writeCall,
  input  wire logic [DATA_W-1:0] dataIn,
  input  wire logic              selWriteStatus,
  input  wire logic              atLoadPoint,
  input  wire logic              echoPulse,
  output logic                   busy,
  output logic                   adapterError,
  output logic                   setWriteStatus,
  output logic                   goTape,
  output logic [DATA_W-1:0]      tapeData,
  output logic                   writePulse,
  output logic                   readCond
);
  localparam int MS_W  = $clog2(DELAY_STEP_CYC + 1);
  localparam int DRV_W = $clog2(DRIVE_CYC_A + DRIVE_CYC_B + 1);

  // Pin synchronisers
  logic              callMeta_ff, callSync_ff, callLast_ff;
  logic              selMeta_ff, selSync_ff;
  logic              lpMeta_ff, lpSync_ff;
  logic              echoMeta_ff, echoSync_ff, echoLast_ff;
  logic [DATA_W-1:0] dataMeta_ff, dataSync_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      callMeta_ff <= 1'b0;
      callSync_ff <= 1'b0;
      callLast_ff <= 1'b0;
      selMeta_ff  <= 1'b0;
      selSync_ff  <= 1'b0;
      lpMeta_ff   <= 1'b0;
      lpSync_ff   <= 1'b0;
      echoMeta_ff <= 1'b0;
      echoSync_ff <= 1'b0;
      echoLast_ff <= 1'b0;
      dataMeta_ff <= '0;
      dataSync_ff <= '0;
    end else begin
      callMeta_ff <= writeCall;
      callSync_ff <= callMeta_ff;
      callLast_ff <= callSync_ff;
      selMeta_ff  <= selWriteStatus;
      selSync_ff  <= selMeta_ff;
      lpMeta_ff   <= atLoadPoint;
      lpSync_ff   <= lpMeta_ff;
      echoMeta_ff <= echoPulse;
      echoSync_ff <= echoMeta_ff;
      echoLast_ff <= echoSync_ff;
      dataMeta_ff <= dataIn;
      dataSync_ff <= dataMeta_ff;
    end
  end

  // APB slave
  logic        pready_ff, pslverr_ff;
  logic [31:0] prdata_ff;
  logic        nxt_pready, nxt_pslverr;
  logic [31:0] nxt_prdata;
  logic        oddSel_ff, modelSel_ff, nxt_oddSel, nxt_modelSel;
  logic        apbSetup, apbWrite, wrCtrl, wrErr, stopReq;
  logic [2:0]  errBits;
  logic [31:0] statusWord;

  tws_pkg::tws_phase_t phase_ff, nxt_phase;
  logic [tws_pkg::DCNT_W-1:0] delayCnt_ff, nxt_delayCnt;
  logic [MS_W-1:0]   msCnt_ff, nxt_msCnt;
  logic [DRV_W-1:0]  drvCnt_ff, nxt_drvCnt;
  logic [3:0]        step_ff, nxt_step;
  logic              lp_ff, nxt_lp, go_ff, nxt_go, readCond_ff, nxt_readCond;
  logic              release_ff, nxt_release, noEcho_ff, nxt_noEcho;
  logic              writePulse_ff, nxt_writePulse;
  logic              parErr_ff, nxt_parErr, echoErr_ff, nxt_echoErr;
  logic              adapterErr_ff, nxt_adapterErr;
  logic              busy_ff, nxt_busy, setWs_ff, nxt_setWs;
  logic [DATA_W-1:0] charReg_ff, nxt_charReg;
  logic              msTick, drvTick, delayEnd, parityErr, echoRise;
  logic [DRV_W-1:0]  drvLast;

  assign errBits    = {adapterErr_ff, echoErr_ff, parErr_ff};
  assign statusWord = {20'h0_0000, step_ff, release_ff, noEcho_ff, lp_ff, readCond_ff,
                       go_ff, (phase_ff == tws_pkg::PH_WRITE),
                       (phase_ff == tws_pkg::PH_START), busy_ff};

  always_comb begin
    apbSetup     = psel & ~penable;
    apbWrite     = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    wrCtrl       = apbWrite & (paddr == tws_pkg::CTRL_OFS);
    wrErr        = apbWrite & (paddr == tws_pkg::ERROR_OFS);
    stopReq      = wrCtrl & pwdata[tws_pkg::CTRL_STOP_BIT];
    nxt_pready   = apbSetup;
    nxt_pslverr  = 1'b0;
    nxt_prdata   = 32'h0000_0000;
    nxt_oddSel   = oddSel_ff;
    nxt_modelSel = modelSel_ff;
    if (apbSetup) begin
      case (paddr)
        tws_pkg::CTRL_OFS: begin
          nxt_prdata[tws_pkg::CTRL_ODD_BIT]   = oddSel_ff;
          nxt_prdata[tws_pkg::CTRL_MODEL_BIT] = modelSel_ff;
        end
        tws_pkg::STATUS_OFS: nxt_prdata = statusWord;
        tws_pkg::ERROR_OFS: nxt_prdata[2:0] = errBits;
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (wrCtrl) begin
      nxt_oddSel   = pwdata[tws_pkg::CTRL_ODD_BIT];
      nxt_modelSel = pwdata[tws_pkg::CTRL_MODEL_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      prdata_ff   <= 32'h0000_0000;
      oddSel_ff   <= tws_pkg::CTRL_ODD_RESET;
      modelSel_ff <= tws_pkg::CTRL_MODEL_RESET;
    end else begin
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      prdata_ff   <= nxt_prdata;
      oddSel_ff   <= nxt_oddSel;
      modelSel_ff <= nxt_modelSel;
    end
  end

  // Sequencer
  always_comb begin
    nxt_phase      = phase_ff;
    nxt_delayCnt   = delayCnt_ff;
    nxt_msCnt      = '0;
    nxt_drvCnt     = '0;
    nxt_step       = step_ff;
    nxt_lp         = lp_ff;
    nxt_go         = go_ff;
    nxt_readCond   = readCond_ff;
    nxt_release    = release_ff;
    nxt_noEcho     = noEcho_ff;
    nxt_writePulse = 1'b0;
    nxt_charReg    = charReg_ff;
    nxt_parErr     = parErr_ff;
    nxt_echoErr    = echoErr_ff;
    nxt_adapterErr = adapterErr_ff;
    echoRise  = echoSync_ff & ~echoLast_ff;
    msTick    = (msCnt_ff == MS_W'(DELAY_STEP_CYC - 1));
    drvLast   = modelSel_ff ? DRV_W'(DRIVE_CYC_B - 1) : DRV_W'(DRIVE_CYC_A - 1);
    drvTick   = (drvCnt_ff == drvLast);
    parityErr = oddSel_ff ? ~(^charReg_ff) : (^charReg_ff);
    delayEnd  = lp_ff ? (delayCnt_ff == tws_pkg::START_DELAY_COUNT_LOAD_POINT)
                      : (delayCnt_ff == tws_pkg::START_DELAY_COUNT_SHORT);
    if (wrErr) begin
      nxt_parErr     = parErr_ff & ~pwdata[tws_pkg::ERR_PARITY_BIT];
      nxt_echoErr    = echoErr_ff & ~pwdata[tws_pkg::ERR_ECHO_BIT];
      nxt_adapterErr = adapterErr_ff & ~pwdata[tws_pkg::ERR_ADAPTER_BIT];
    end
    if (echoRise) begin
      nxt_noEcho = 1'b0;
    end
    case (phase_ff)
      tws_pkg::PH_IDLE: begin
        if (callSync_ff & ~callLast_ff) begin
          nxt_phase    = tws_pkg::PH_START;
          nxt_lp       = lpSync_ff;
          nxt_delayCnt = '0;
        end
      end
      tws_pkg::PH_START: begin
        // Stalls here while a protected unit withholds write status
        if (selSync_ff) begin
          nxt_go    = 1'b1;
          nxt_msCnt = msTick ? '0 : msCnt_ff + MS_W'(1);
          if (msTick) begin
            nxt_delayCnt = delayCnt_ff + tws_pkg::DCNT_W'(1);
          end
          if ((~lp_ff & (delayCnt_ff == tws_pkg::DELAY_COUNT_READ_ENABLE)) |
              (lp_ff & delayEnd)) begin
            nxt_readCond = 1'b1;
          end
          if (delayEnd) begin
            nxt_phase    = tws_pkg::PH_WRITE;
            nxt_delayCnt = '0;
            nxt_msCnt    = '0;
            nxt_release  = 1'b1;
          end
        end
      end
      tws_pkg::PH_WRITE: begin
        nxt_drvCnt = drvTick ? '0 : drvCnt_ff + DRV_W'(1);
        if (drvTick) begin
          if ((step_ff == tws_pkg::WRITE_STEP_LAST) ||
              (step_ff == tws_pkg::WRITE_STEP_IDLE)) begin
            nxt_step = tws_pkg::WRITE_STEP_ONE;
          end else begin
            nxt_step = step_ff + 4'h1;
          end
          case (nxt_step)
            tws_pkg::WRITE_STEP_ONE: nxt_charReg = '0;
            tws_pkg::WRITE_STEP_THREE: nxt_charReg = dataSync_ff;
            tws_pkg::WRITE_STEP_FIVE: nxt_noEcho = 1'b1;
            tws_pkg::WRITE_STEP_NINE: begin
              nxt_writePulse = 1'b1;
              if (parityErr) begin
                nxt_parErr     = 1'b1;
                nxt_adapterErr = 1'b1;
              end
            end
            tws_pkg::WRITE_STEP_FOURTEEN: begin
              if (noEcho_ff & ~echoRise) begin
                nxt_echoErr    = 1'b1;
                nxt_adapterErr = 1'b1;
              end
            end
            default: nxt_charReg = charReg_ff;
          endcase
        end
      end
      default: nxt_phase = tws_pkg::PH_IDLE;
    endcase
    if (stopReq) begin
      nxt_phase      = tws_pkg::PH_IDLE;
      nxt_delayCnt   = '0;
      nxt_msCnt      = '0;
      nxt_drvCnt     = '0;
      nxt_step       = tws_pkg::WRITE_STEP_IDLE;
      nxt_go         = 1'b0;
      nxt_readCond   = 1'b0;
      nxt_release    = 1'b0;
      nxt_noEcho     = 1'b0;
      nxt_writePulse = 1'b0;
      nxt_charReg    = '0;
    end
    nxt_busy  = (nxt_phase != tws_pkg::PH_IDLE);
    nxt_setWs = (nxt_phase != tws_pkg::PH_IDLE);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff      <= tws_pkg::PH_IDLE;
      delayCnt_ff   <= '0;
      msCnt_ff      <= '0;
      drvCnt_ff     <= '0;
      step_ff       <= tws_pkg::WRITE_STEP_IDLE;
      lp_ff         <= 1'b0;
      go_ff         <= 1'b0;
      readCond_ff   <= 1'b0;
      release_ff    <= 1'b0;
      noEcho_ff     <= 1'b0;
      writePulse_ff <= 1'b0;
      charReg_ff    <= '0;
      parErr_ff     <= 1'b0;
      echoErr_ff    <= 1'b0;
      adapterErr_ff <= 1'b0;
      busy_ff       <= 1'b0;
      setWs_ff      <= 1'b0;
    end else begin
      phase_ff      <= nxt_phase;
      delayCnt_ff   <= nxt_delayCnt;
      msCnt_ff      <= nxt_msCnt;
      drvCnt_ff     <= nxt_drvCnt;
      step_ff       <= nxt_step;
      lp_ff         <= nxt_lp;
      go_ff         <= nxt_go;
      readCond_ff   <= nxt_readCond;
      release_ff    <= nxt_release;
      noEcho_ff     <= nxt_noEcho;
      writePulse_ff <= nxt_writePulse;
      charReg_ff    <= nxt_charReg;
      parErr_ff     <= nxt_parErr;
      echoErr_ff    <= nxt_echoErr;
      adapterErr_ff <= nxt_adapterErr;
      busy_ff       <= nxt_busy;
      setWs_ff      <= nxt_setWs;
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign busy           = busy_ff;
  assign adapterError   = adapterErr_ff;
  assign setWriteStatus = setWs_ff;
  assign goTape         = go_ff;
  assign tapeData       = charReg_ff;
  assign writePulse     = writePulse_ff;
  assign readCond       = readCond_ff;
endmodule
`default_nettype wire

// [sim/tws_sequencer_properties.sv]
/*
  Concurrent checks on the ports of the tape write sequencer.
  Assumes the parity select is changed only while the sequencer is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module tws_sequencer_checker #(
  parameter int DATA_W = 7
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              busy,
  input wire logic              adapterError,
  input wire logic              setWriteStatus,
  input wire logic              goTape,
  input wire logic [DATA_W-1:0] tapeData,
  input wire logic              writePulse,
  input wire logic              readCond
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic oddSel_ff;
  logic nxt_oddSel;
  logic errClr;
  // Shadow of the parity select
  always_comb begin
    nxt_oddSel = oddSel_ff;
    errClr = psel && penable && pwrite && paddr == tws_pkg::ERROR_OFS;
    if (psel && penable && pready && pwrite && paddr == tws_pkg::CTRL_OFS) begin
      nxt_oddSel = pwdata[tws_pkg::CTRL_ODD_BIT];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) oddSel_ff <= tws_pkg::CTRL_ODD_RESET;
    else oddSel_ff <= nxt_oddSel;
  end
  statusFollows_a: assert property (setWriteStatus == busy)
    else $error("write status request differs from busy");
  goNeedsBusy_a: assert property (goTape |-> busy)
    else $error("go without busy");
  goNotFirst_a: assert property ($rose(busy) |-> !goTape)
    else $error("go together with write call");
  goDrop_a: assert property ($fell(goTape) |-> !busy)
    else $error("go dropped while busy");
  pulseSingle_a: assert property (writePulse |=> !writePulse)
    else $error("write pulse longer than one cycle");
  pulseInWrite_a: assert property (writePulse |-> goTape && readCond)
    else $error("write pulse outside write condition");
  dataHeld_a: assert property (writePulse |-> tapeData == $past(tapeData, 2))
    else $error("character moved at write pulse");
  parityFlag_a: assert property (writePulse && ((^tapeData) != oddSel_ff) |-> adapterError)
    else $error("parity error not flagged");
  errSticky_a: assert property (adapterError && !errClr |=> adapterError)
    else $error("adapter error lost");
  readBusy_a: assert property (readCond |-> busy)
    else $error("read condition while idle");
  cover property ($rose(readCond));
  cover property (writePulse && adapterError);
  cover property ((busy && !goTape) [*8]);
endmodule
bind tws_sequencer tws_sequencer_checker #(.DATA_W(DATA_W)) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .busy(busy), .adapterError(adapterError),
  .setWriteStatus(setWriteStatus), .goTape(goTape), .tapeData(tapeData),
  .writePulse(writePulse), .readCond(readCond));
`default_nettype wire

// [sim/tws_tape_unit.sv]
/*
  Behavioural tape unit: write status answer and echo pulses.
  Assumes the bench sets protection, echo and lag only between runs.
*/
`timescale 1ns/1ps
`default_nettype none
module tws_tape_unit (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       setWriteStatus,
  input  wire logic       writePulse,
  input  wire logic [6:0] tapeData,
  input  wire logic       fileProtect,
  input  wire logic       echoEnable,
  input  wire logic [3:0] selLag,
  output logic            selWriteStatus,
  output logic            echoPulse
);
  int lagCnt;
  int echoCnt;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lagCnt = 0;
      echoCnt = 0;
      selWriteStatus <= 1'b0;
      echoPulse <= 1'b0;
    end else begin
      if (!setWriteStatus || fileProtect) lagCnt = 0;
      else if (lagCnt < selLag) lagCnt++;
      selWriteStatus <= setWriteStatus && !fileProtect && lagCnt >= selLag;
      if (writePulse && echoEnable && tapeData != 7'h00) echoCnt = 6;
      else if (echoCnt > 0) echoCnt--;
      echoPulse <= echoCnt >= 1 && echoCnt <= 3;
    end
  end
endmodule
`default_nettype wire

// [sim/tws_sequencer_tb_top.sv]
/*
  Self-checking bench of the tape write sequencer over APB.
  Assumes the tape unit model and the bound checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tws_sequencer_tb_top;
  localparam int STEP = 4;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, rnd;
  logic        pready, pslverr, busy, adapterError, setWriteStatus, goTape, writePulse;
  logic        readCond, writeCall = 0, atLoadPoint = 0, selWriteStatus, echoPulse;
  logic        fileProtect = 0, echoEnable = 1;
  logic [6:0]  dataIn = 0, tapeData;
  integer      seed = 32'hbc9e;
  int          fails = 0, testsRun = 0, n, lp, drive;
  logic        parE, echoE;
  always #2.5 sys_clk = ~sys_clk;
  tws_sequencer #(.DELAY_STEP_CYC(STEP), .DRIVE_CYC_A(3), .DRIVE_CYC_B(2)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .writeCall(writeCall), .dataIn(dataIn), .selWriteStatus(selWriteStatus),
    .atLoadPoint(atLoadPoint), .echoPulse(echoPulse), .busy(busy),
    .adapterError(adapterError), .setWriteStatus(setWriteStatus), .goTape(goTape),
    .tapeData(tapeData), .writePulse(writePulse), .readCond(readCond));
  tws_tape_unit tape (
    .sys_clk(sys_clk), .rst_n(rst_n), .setWriteStatus(setWriteStatus),
    .writePulse(writePulse), .tapeData(tapeData), .fileProtect(fileProtect),
    .echoEnable(echoEnable), .selLag(4'h8), .selWriteStatus(selWriteStatus),
    .echoPulse(echoPulse));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic call();
    @(posedge sys_clk);
    writeCall <= 1'b1;
    repeat (4) @(posedge sys_clk);
    writeCall <= 1'b0;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    apb(1'b0, tws_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b0, 12'h00c, 32'h0);
    check(32'(se), 32'h0000_0001);
    // Protected unit: start-up stalls before go
    fileProtect <= 1'b1;
    call();
    repeat (40) @(posedge sys_clk);
    apb(1'b0, tws_pkg::STATUS_OFS, 32'h0);
    check(rd & 32'h0000_001f, 32'h0000_0003);
    apb(1'b1, tws_pkg::CTRL_OFS, 32'h0000_0005);
    apb(1'b0, tws_pkg::STATUS_OFS, 32'h0);
    check(rd, 32'h0000_0000);
    fileProtect <= 1'b0;
    for (lp = 0; lp < 2; lp++) begin
      drive = lp ? 2 : 3;
      apb(1'b1, tws_pkg::CTRL_OFS, lp ? 32'h0000_0002 : 32'h0000_0001);
      atLoadPoint <= lp[0];
      echoEnable <= !lp[0];
      dataIn <= lp ? 7'h03 : 7'h01;
      call();
      apb(1'b0, tws_pkg::STATUS_OFS, 32'h0);
      check(rd & 32'h0000_002b, 32'h3 | 32'(lp << 5));
      n = 0;
      while (goTape !== 1'b1 && n < 50) begin
        @(posedge sys_clk);
        n++;
      end
      n = 0;
      while (readCond !== 1'b1 && n < 2000) begin
        @(posedge sys_clk);
        n++;
      end
      check(32'(n inside {[(lp ? 320 : 32) * STEP - 2 : (lp ? 320 : 32) * STEP + 3]}), 1);
      apb(1'b0, tws_pkg::STATUS_OFS, 32'h0);
      check(rd & 32'h0000_00bf, 32'h9d | 32'(lp << 5));
      parE = 0;
      echoE = 0;
      n = 0;
      for (int k = 0; k < 4; k++) begin
        do begin
          @(posedge sys_clk);
          n++;
        end while (writePulse !== 1'b1 && n < 200);
        if (k > 0) check(n, 14 * drive);
        parE |= (($countones(dataIn) % 2) == 0) == (lp == 0);
        check(32'(tapeData), 32'(dataIn));
        check(32'(adapterError), 32'(parE | echoE));
        echoE |= !echoEnable || dataIn == 7'h00;
        rnd = $random(seed);
        dataIn <= rnd[6:0];
        repeat (7 * drive) @(posedge sys_clk);
        check(32'(tapeData), 32'h0);
        n = 7 * drive;
      end
      apb(1'b0, tws_pkg::ERROR_OFS, 32'h0);
      check(rd & 32'h7, 32'({parE | echoE, echoE, parE}));
      apb(1'b1, tws_pkg::CTRL_OFS, lp ? 32'h0000_0006 : 32'h0000_0005);
      apb(1'b1, tws_pkg::ERROR_OFS, 32'h0000_0007);
      apb(1'b0, tws_pkg::ERROR_OFS, 32'h0);
      check(rd, 32'h0000_0000);
    end
    conclude();
  end
endmodule
`default_nettype wire
